// ### src/option_bit_shadow_loader.v
// Option byte shadow loader: copies configuration bytes from flash into shadow flip-flops at the end of a power-on or long stop recovery reset
`timescale 1ns/1ps
`include "option_loader_map.vh"

module option_bit_shadow_loader (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Reset sequencer
  input wire por_reset,
  input wire stop_recovery_reset,
  input wire [7:0] stop_recovery_control,
  input wire reset_tail,
  output reg load_done_ff,
  // Flash information block
  output reg [7:0] info_addr_ff,
  output reg info_rd_ff,
  input wire [7:0] info_data,
  // CPU register file
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  output reg reg_hit_ff,
  // Configuration outputs
  output reg watchdog_policy_select_ff,
  output reg port4_pullup_n_ff,
  output reg port3_pullup_n_ff,
  output reg port2_pullup_n_ff,
  output reg port1_upper_pullup_n_ff,
  output reg port1_lower_pullup_n_ff,
  output reg port0_upper_pullup_n_ff,
  output reg port0_lower_pullup_n_ff,
  output reg wide_stack_select_ff,
  output reg clock_halving_select_ff,
  output reg lower_half_guard_ff,
  output reg main_array_guard_ff,
  output reg sys_clk_half_ff
);

  localparam ST_IDLE = 2'd0;
  localparam ST_LOW = 2'd1;
  localparam ST_HIGH = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] user_config_byte_low_copy_ff;
  reg [3:0] high_copy_ff;
  reg [1:0] guard_ff;
  reg por_seen_ff;
  reg load_req_ff;
  reg fetch_start;
  reg [7:0] fetch_addr;
  wire fetch_done;
  wire [7:0] fetch_data;
  wire [7:0] fetch_info_addr;
  wire fetch_info_rd;

  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  option_byte_fetch u_fetch (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(fetch_start),
    .addr(fetch_addr),
    .info_addr_ff(fetch_info_addr),
    .info_rd_ff(fetch_info_rd),
    .info_data(info_data),
    .done_ff(fetch_done),
    .data_ff(fetch_data)
  );

  // Remember which reset kind asks for a reload
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_req_ff <= 1'b0;
      por_seen_ff <= 1'b0;
    end else begin
      if (por_reset || (stop_recovery_reset && stop_recovery_control[`STOP_REC_LONG_BIT])) begin
        load_req_ff <= 1'b1;
        por_seen_ff <= por_reset;
      end else if (state_ff == ST_DONE) begin
        load_req_ff <= 1'b0;
        por_seen_ff <= 1'b0;
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    fetch_start = 1'b0;
    fetch_addr = `CFG_LOW_FLASH_ADDR;
    case (state_ff)
      ST_IDLE: begin
        if (load_req_ff && reset_tail) begin
          fetch_start = 1'b1;
          nxt_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (fetch_done) begin
          fetch_start = 1'b1;
          fetch_addr = `CFG_HIGH_FLASH_ADDR;
          nxt_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (fetch_done) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      // Preset before the flash copy; erased value gives safe defaults
      user_config_byte_low_copy_ff <= `CFG_PRESET_VAL;
      high_copy_ff <= `HIGH_RSVD_VAL;
      load_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_DONE) begin
        load_done_ff <= 1'b1;
      end
      if (state_ff == ST_LOW && fetch_done) begin
        user_config_byte_low_copy_ff <= fetch_data;
      end else if (reg_wr && hit(reg_addr, `CFG_LOW_COPY_ADDR)) begin
        user_config_byte_low_copy_ff <= reg_wdata;
      end
      if (state_ff == ST_HIGH && fetch_done) begin
        high_copy_ff <= fetch_data[3:0];
      end else if (reg_wr && hit(reg_addr, `CFG_HIGH_COPY_ADDR)) begin
        // Guard bits keep their sampled value
        high_copy_ff[3:2] <= reg_wdata[3:2];
      end
    end
  end

  // Guards have no reset, so a stop recovery reset cannot drop protection
  always @(posedge clk_sys) begin
    if (state_ff == ST_HIGH && fetch_done && por_seen_ff) begin
      guard_ff <= fetch_data[1:0];
    end
  end

  // Register file reads
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
      reg_hit_ff <= 1'b0;
    end else begin
      reg_hit_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
      if (reg_rd) begin
        if (hit(reg_addr, `CFG_LOW_COPY_ADDR)) begin
          reg_rdata_ff <= user_config_byte_low_copy_ff;
          reg_hit_ff <= 1'b1;
        end else if (hit(reg_addr, `CFG_HIGH_COPY_ADDR)) begin
          reg_rdata_ff <= {`HIGH_RSVD_VAL, high_copy_ff[3:2], guard_ff};
          reg_hit_ff <= 1'b1;
        end else if (hit(reg_addr, `GUARD_STATUS_ADDR)) begin
          reg_rdata_ff <= {6'h00, guard_ff};
          reg_hit_ff <= 1'b1;
        end
      end
    end
  end

  // Registered configuration outputs
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      info_addr_ff <= 8'h00;
      info_rd_ff <= 1'b0;
      watchdog_policy_select_ff <= 1'b1;
      {port4_pullup_n_ff, port3_pullup_n_ff, port2_pullup_n_ff} <= 3'h7;
      {port1_upper_pullup_n_ff, port1_lower_pullup_n_ff} <= 2'h3;
      {port0_upper_pullup_n_ff, port0_lower_pullup_n_ff} <= 2'h3;
      wide_stack_select_ff <= 1'b1;
      clock_halving_select_ff <= 1'b1;
      lower_half_guard_ff <= 1'b0;
      main_array_guard_ff <= 1'b0;
      sys_clk_half_ff <= 1'b0;
    end else begin
      info_addr_ff <= fetch_info_addr;
      info_rd_ff <= fetch_info_rd;
      watchdog_policy_select_ff <= user_config_byte_low_copy_ff[`LOW_WATCHDOG_BIT];
      port4_pullup_n_ff <= user_config_byte_low_copy_ff[6];
      port3_pullup_n_ff <= user_config_byte_low_copy_ff[5];
      port2_pullup_n_ff <= user_config_byte_low_copy_ff[4];
      port1_upper_pullup_n_ff <= user_config_byte_low_copy_ff[3];
      port1_lower_pullup_n_ff <= user_config_byte_low_copy_ff[2];
      port0_upper_pullup_n_ff <= user_config_byte_low_copy_ff[1];
      port0_lower_pullup_n_ff <= user_config_byte_low_copy_ff[0];
      wide_stack_select_ff <= high_copy_ff[`HIGH_WIDE_STACK_BIT];
      clock_halving_select_ff <= high_copy_ff[`HIGH_CLK_HALF_BIT];
      lower_half_guard_ff <= guard_ff[`HIGH_LOWER_GUARD_BIT];
      main_array_guard_ff <= guard_ff[`HIGH_MAIN_GUARD_BIT];
      sys_clk_half_ff <= high_copy_ff[`HIGH_CLK_HALF_BIT] &
                         ~stop_recovery_control[`STOP_REC_DIV_BIT];
    end
  end

endmodule

// ### shared/option_loader_map.vh
// Register addresses, flash locations, field positions and timing counts of the option loader
`ifndef OPTION_LOADER_MAP_VH
`define OPTION_LOADER_MAP_VH

`define CFG_LOW_COPY_ADDR 12'h0D0E
`define CFG_HIGH_COPY_ADDR 12'h0D0F
`define GUARD_STATUS_ADDR 12'h0D0D

`define CFG_LOW_FLASH_ADDR 8'hFE
`define CFG_HIGH_FLASH_ADDR 8'hFF

`define LOW_WATCHDOG_BIT 7
`define HIGH_WIDE_STACK_BIT 3
`define HIGH_CLK_HALF_BIT 2
`define HIGH_LOWER_GUARD_BIT 1
`define HIGH_MAIN_GUARD_BIT 0
`define STOP_REC_LONG_BIT 5
`define STOP_REC_DIV_BIT 0

`define CFG_PRESET_VAL 8'hFF
`define HIGH_RSVD_VAL 4'hF

`define FLASH_READ_CYCLES 4'h2

`endif

// ### src/option_byte_fetch.v
// Reads one information-block byte with a fixed read latency
`timescale 1ns/1ps
`include "option_loader_map.vh"

module option_byte_fetch (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Request
  input wire start,
  input wire [7:0] addr,
  // Flash information block
  output reg [7:0] info_addr_ff,
  output reg info_rd_ff,
  input wire [7:0] info_data,
  // Result
  output reg done_ff,
  output reg [7:0] data_ff
);

  reg [3:0] wait_ff;
  reg busy_ff;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      info_addr_ff <= 8'h00;
      info_rd_ff <= 1'b0;
      done_ff <= 1'b0;
      data_ff <= 8'h00;
      wait_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        info_addr_ff <= addr;
        info_rd_ff <= 1'b1;
        busy_ff <= 1'b1;
        wait_ff <= `FLASH_READ_CYCLES;
      end else if (busy_ff) begin
        if (wait_ff == 4'h0) begin
          data_ff <= info_data;
          done_ff <= 1'b1;
          busy_ff <= 1'b0;
          info_rd_ff <= 1'b0;
        end else begin
          wait_ff <= wait_ff - 4'h1;
        end
      end
    end
  end

endmodule

// ### bench/option_loader_checker_assertions.sv
// Port-level assertions of the option byte shadow loader
`timescale 1ns/1ps
module option_loader_checker (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Observed ports
  input wire load_done_ff,
  input wire [7:0] info_addr_ff,
  input wire info_rd_ff,
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire reg_hit_ff,
  input wire watchdog_policy_select_ff,
  input wire port0_lower_pullup_n_ff,
  input wire lower_half_guard_ff,
  input wire main_array_guard_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_low_copy_hit: assert property (reg_rd && reg_addr == 12'h0d0e |=> reg_hit_ff)
    else $error("low copy read not acknowledged");
  chk_unmapped_read: assert property (reg_rd && reg_addr > 12'h0d0f |=> !reg_hit_ff && reg_rdata_ff == 8'h00)
    else $error("unmapped read answered");
  chk_guard_frozen: assert property (load_done_ff && $past(load_done_ff, 2)
    |-> $stable(lower_half_guard_ff) && $stable(main_array_guard_ff))
    else $error("guard changed after load");
  chk_fetch_addr: assert property (info_rd_ff |-> info_addr_ff == 8'hfe || info_addr_ff == 8'hff)
    else $error("fetch outside option bytes");
  chk_strobe_width: assert property ($rose(info_rd_ff) |-> info_rd_ff [*3] ##1 !info_rd_ff)
    else $error("read strobe width wrong");
  chk_addr_steady: assert property (info_rd_ff && $past(info_rd_ff) |-> $stable(info_addr_ff))
    else $error("fetch address moved during read");
  chk_done_sticky: assert property (load_done_ff |=> load_done_ff)
    else $error("load done dropped");
  chk_load_bound: assert property ($rose(info_rd_ff) && info_addr_ff == 8'hfe |-> ##[1:20] load_done_ff)
    else $error("load did not complete");
  chk_write_output: assert property (reg_wr && reg_addr == 12'h0d0e && load_done_ff
    |-> ##2 watchdog_policy_select_ff == $past(reg_wdata[7], 2)
    && port0_lower_pullup_n_ff == $past(reg_wdata[0], 2))
    else $error("written byte not on outputs");
endmodule
bind option_bit_shadow_loader option_loader_checker u_chk (.clk_sys(clk_sys), .reset(reset),
  .load_done_ff(load_done_ff), .info_addr_ff(info_addr_ff), .info_rd_ff(info_rd_ff), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_hit_ff(reg_hit_ff),
  .watchdog_policy_select_ff(watchdog_policy_select_ff), .port0_lower_pullup_n_ff(port0_lower_pullup_n_ff),
  .lower_half_guard_ff(lower_half_guard_ff), .main_array_guard_ff(main_array_guard_ff));

// ### bench/flash_info_model.sv
// Information block model holding the two option bytes
`timescale 1ns/1ps
module flash_info_model (
  // Clock
  input wire clk_sys,
  // Read port
  input wire [7:0] info_addr_ff,
  input wire info_rd_ff,
  output wire [7:0] info_data,
  // Stored bytes, set only by the bench in place of the programming port
  input wire [7:0] byte0,
  input wire [7:0] byte1
);
  reg [7:0] junk_ff = 8'h00;
  always @(posedge clk_sys) begin
    junk_ff <= junk_ff + 8'h5b;
  end
  // Idle bus shows a changing pattern; reserved high bits stored as ones
  assign info_data = !info_rd_ff ? junk_ff : info_addr_ff == 8'hfe ? byte0 :
    info_addr_ff == 8'hff ? {4'hf, byte1[3:0]} : ~junk_ff;
endmodule

// ### bench/tb_option_bit_shadow_loader.sv
// Self-checking bench of the option byte shadow loader
`timescale 1ns/1ps
module tb_option_bit_shadow_loader;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg por_reset = 1'b0;
  reg stop_recovery_reset = 1'b0;
  reg [7:0] stop_recovery_control = 8'h00;
  reg reset_tail = 1'b0;
  reg [11:0] reg_addr = 12'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg [7:0] byte0 = 8'hff;
  reg [7:0] byte1 = 8'hff;
  reg [31:0] seed = 32'h0001_31c1;
  reg [7:0] rd;
  reg [7:0] d;
  reg hit;
  integer mismatches = 0;
  integer n_tests = 0;
  integer i;
  integer k;
  wire [7:0] info_addr_ff, info_data, reg_rdata_ff;
  wire [6:0] pu;
  wire [1:0] gd;
  wire load_done_ff, info_rd_ff, reg_hit_ff, wdog, stk, half, sys_clk_half_ff;
  always #12.5 clk_sys = ~clk_sys;
  option_bit_shadow_loader DUT (.clk_sys(clk_sys), .reset(reset), .por_reset(por_reset),
    .stop_recovery_reset(stop_recovery_reset), .stop_recovery_control(stop_recovery_control),
    .reset_tail(reset_tail), .load_done_ff(load_done_ff), .info_addr_ff(info_addr_ff), .info_rd_ff(info_rd_ff),
    .info_data(info_data), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_hit_ff(reg_hit_ff), .watchdog_policy_select_ff(wdog),
    .port4_pullup_n_ff(pu[6]), .port3_pullup_n_ff(pu[5]), .port2_pullup_n_ff(pu[4]),
    .port1_upper_pullup_n_ff(pu[3]), .port1_lower_pullup_n_ff(pu[2]), .port0_upper_pullup_n_ff(pu[1]),
    .port0_lower_pullup_n_ff(pu[0]), .wide_stack_select_ff(stk), .clock_halving_select_ff(half),
    .lower_half_guard_ff(gd[1]), .main_array_guard_ff(gd[0]), .sys_clk_half_ff(sys_clk_half_ff));
  flash_info_model u_flash (.clk_sys(clk_sys), .info_addr_ff(info_addr_ff), .info_rd_ff(info_rd_ff),
    .info_data(info_data), .byte0(byte0), .byte1(byte1));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // High copy: reserved read as ones, guard bits from the guard flip-flops
  function [7:0] hi_exp(input [7:0] b, input [1:0] g);
    hi_exp = {4'hf, b[3:2], g};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [11:0] a, input [7:0] v);
    begin
      @(negedge clk_sys);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd = reg_rdata_ff;
      hit = reg_hit_ff;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task boot(input p, input s, input [7:0] c);
    begin
      @(negedge clk_sys);
      reset = 1'b1;
      por_reset = p;
      stop_recovery_reset = s;
      stop_recovery_control = c;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      reset_tail = 1'b1;
      for (i = 0; i < 40 && load_done_ff !== 1'b1; i = i + 1) @(negedge clk_sys);
      reset_tail = 1'b0;
      por_reset = 1'b0;
      stop_recovery_reset = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
  endtask
  task outs(input [7:0] b0, input [7:0] b1, input [1:0] g);
    begin
      chk({wdog, pu}, b0);
      chk({stk, half, gd}, {b1[3:2], g});
      chk({7'h00, sys_clk_half_ff}, {7'h00, b1[2] & ~stop_recovery_control[0]});
      acc(1'b0, 12'h0d0e, 8'h00);
      chk(rd, b0);
      chk({7'h00, hit}, 8'h01);
      acc(1'b0, 12'h0d0f, 8'h00);
      chk(rd, hi_exp(b1, g));
      acc(1'b0, 12'h0d0d, 8'h00);
      chk({6'h00, rd[1:0]}, {6'h00, g});
    end
  endtask
  task results;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    for (k = 0; k < 4; k = k + 1) begin
      seed = xs(seed);
      byte0 = k == 0 ? 8'hff : k == 1 ? 8'h00 : seed[7:0];
      byte1 = k == 0 ? 8'hff : {4'hf, seed[11:8]};
      boot(1'b1, 1'b0, {7'h00, seed[12]});
      outs(byte0, byte1, byte1[1:0]);
    end
    d = seed[23:16];
    acc(1'b1, 12'h0d0e, d);
    chk({wdog, pu}, d);
    acc(1'b1, 12'h0d0f, 8'h00);
    acc(1'b1, 12'h0d0d, 8'hff);
    byte0 = ~byte0;
    outs(d, 8'hf0, byte1[1:0]);
    acc(1'b0, 12'h0d20, 8'h00);
    chk(rd, 8'h00);
    chk({7'h00, hit}, 8'h00);
    boot(1'b0, 1'b1, 8'h00);
    chk({7'h00, load_done_ff}, 8'h00);
    outs(8'hff, 8'hff, byte1[1:0]);
    seed = xs(seed);
    d = byte1;
    byte0 = seed[7:0];
    byte1 = {4'hf, seed[11:8]};
    boot(1'b0, 1'b1, 8'h20);
    outs(byte0, byte1, d[1:0]);
    results;
  end
endmodule
